/* File: logic/vte_engine.sv */
// vte_engine: coordinate transform engine behind a parallel register port.
// assumes a host that keeps the port timing of vte_host and one clock.
// Operation
// - reverse angle write starts reverse transform
// - host loads phase inputs before reverse angle
// - two-input mode derives phase a as -(b+c)
// - control bit 10 selects three-input mode
// - reverse results ready 37 cycles later
// - forward results ready 40 cycles later
// - control bit 6 enables completion interrupt
// - completion sets status bit 1
// - forward angle write starts forward transform
// - host sets three-input mode before forward
// - one transform at a time
// - angles unsigned turn fractions, others signed
// - host writes no register but control during a transform
// - reverse clarke: alpha=a, beta=(c-b)/sqrt3
// - reverse park gives flux and torque
// - sine and cosine generated internally
// - forward park rotates direct/quadrature voltages
// - forward clarke expands to three phases
// - reset held low two cycles
// - enabled interrupt sets summary bit 11
// - status read or reset clears flags
// - control bit 8 selects pulse or level irq
`timescale 1ns/10ps
`default_nettype none
`include "vte_defines.svh"
module vte_engine
  import vte_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port and interrupt line
  vte_port_if.dev port
);
  typedef struct packed {
    logic [1:0] s_cs_n;
    logic [1:0] s_rd_n;
    logic [1:0] s_wr_n;
    logic wr_d;
    logic rd_d;
    logic [3:0] s_addr0;
    logic [3:0] s_addr1;
    logic [11:0] s_dat0;
    logic [11:0] s_dat1;
    vte_word_t ph_a;
    vte_word_t ph_b;
    vte_word_t ph_c;
    logic [11:0] rev_ang;
    logic [11:0] fwd_ang;
    vte_word_t vd;
    vte_word_t vq;
    vte_word_t flux;
    vte_word_t torque;
    vte_word_t ialpha;
    vte_word_t ibeta;
    vte_word_t pv_a;
    vte_word_t pv_b;
    vte_word_t pv_c;
    logic [11:0] ctrl;
    logic flag_xform;
    logic flag_sum;
    logic busy;
    logic fwd;
    logic [5:0] cnt;
    logic signed [17:0] cx;
    logic signed [17:0] cy;
    logic signed [17:0] cz;
    logic [3:0] iter;
    logic [11:0] rdata;
    logic drive;
    logic irq_pulse;
  } vte_eng_state_t;

  vte_eng_state_t st;
  vte_eng_state_t next_st;

  // ==================== arithmetic helpers
  // arctangent of 2^-i in 65536ths of a turn
  function automatic logic signed [17:0] vte_atan(input logic [3:0] i);
    unique case (i)
      4'h0: return 18'sd8192;
      4'h1: return 18'sd4836;
      4'h2: return 18'sd2555;
      4'h3: return 18'sd1297;
      4'h4: return 18'sd651;
      4'h5: return 18'sd326;
      4'h6: return 18'sd163;
      4'h7: return 18'sd81;
      4'h8: return 18'sd41;
      4'h9: return 18'sd20;
      4'hA: return 18'sd10;
      4'hB: return 18'sd5;
      4'hC: return 18'sd3;
      default: return 18'sd1;
    endcase
  endfunction

  // product with a Q2.14 factor, scaled back
  function automatic logic signed [31:0] vte_mul(input logic signed [31:0] a,
                                                 input logic signed [31:0] k);
    logic signed [31:0] p;
    p = a * k;
    return p >>> 14;
  endfunction

  // clamp to the 12-bit twos complement range
  function automatic vte_word_t vte_sat(input logic signed [31:0] v);
    if (v > 32'sd2047) begin
      return 12'sh7FF;
    end else if (v < -32'sd2048) begin
      return 12'sh800;
    end
    return v[11:0];
  endfunction

  // ==================== next-state logic
  always_comb begin
    logic wr_edge;
    logic rd_edge;
    logic start;
    logic done;
    logic [11:0] ang;
    logic signed [31:0] c;
    logic signed [31:0] s;
    logic signed [31:0] a;
    logic signed [31:0] b;
    logic signed [31:0] cc;
    logic signed [31:0] vx;
    logic signed [31:0] vy;
    vte_word_t al;
    vte_word_t be;
    wr_edge = 1'b0;
    rd_edge = 1'b0;
    start = 1'b0;
    done = 1'b0;
    ang = 12'h000;
    c = 32'sd0;
    s = 32'sd0;
    a = 32'sd0;
    b = 32'sd0;
    cc = 32'sd0;
    vx = 32'sd0;
    vy = 32'sd0;
    al = 12'sh000;
    be = 12'sh000;
    next_st = st;
    // pin synchronisers, two stages each
    next_st.s_cs_n = {st.s_cs_n[0], port.cs_n};
    next_st.s_rd_n = {st.s_rd_n[0], port.rd_n};
    next_st.s_wr_n = {st.s_wr_n[0], port.wr_n};
    next_st.s_addr0 = port.addr;
    next_st.s_addr1 = st.s_addr0;
    next_st.s_dat0 = port.data_bus;
    next_st.s_dat1 = st.s_dat0;
    next_st.wr_d = st.s_wr_n[1];
    next_st.rd_d = st.s_rd_n[1];
    wr_edge = st.s_wr_n[1] && !st.wr_d && !st.s_cs_n[1];
    rd_edge = st.s_rd_n[1] && !st.rd_d && !st.s_cs_n[1];
    // register writes
    if (wr_edge) begin
      unique case (st.s_addr1)
        `VTE_ADDR_PH_A: next_st.ph_a = st.s_dat1;
        `VTE_ADDR_PH_B: next_st.ph_b = st.s_dat1;
        `VTE_ADDR_PH_C: next_st.ph_c = st.s_dat1;
        `VTE_ADDR_VD: next_st.vd = st.s_dat1;
        `VTE_ADDR_VQ: next_st.vq = st.s_dat1;
        `VTE_ADDR_CTRL: next_st.ctrl = st.s_dat1;
        `VTE_ADDR_REV_ANG: begin
          next_st.rev_ang = st.s_dat1;
          start = !st.busy;
          next_st.fwd = st.busy ? st.fwd : 1'b0;
        end
        `VTE_ADDR_FWD_ANG: begin
          next_st.fwd_ang = st.s_dat1;
          start = !st.busy;
          next_st.fwd = st.busy ? st.fwd : 1'b1;
        end
        default: ;
      endcase
    end
    // launch: seed the rotator with the angle residual within its quadrant
    if (start) begin
      ang = next_st.fwd ? st.s_dat1 : st.s_dat1; // unsigned turn fraction
      next_st.busy = 1'b1;
      next_st.cnt = 6'd1;
      next_st.cx = `VTE_KINV;
      next_st.cy = 18'sd0;
      next_st.cz = {4'h0, ang[9:0], 4'h0};
      next_st.iter = 4'h0;
    end else if (st.busy) begin
      next_st.cnt = st.cnt + 6'd1;
      // rotation steps toward the residual angle
      if (st.iter != `VTE_CORDIC_STEPS) begin
        if (!st.cz[17]) begin
          next_st.cx = st.cx - (st.cy >>> st.iter);
          next_st.cy = st.cy + (st.cx >>> st.iter);
          next_st.cz = st.cz - vte_atan(st.iter);
        end else begin
          next_st.cx = st.cx + (st.cy >>> st.iter);
          next_st.cy = st.cy - (st.cx >>> st.iter);
          next_st.cz = st.cz + vte_atan(st.iter);
        end
        next_st.iter = st.iter + 4'h1;
      end
      done = st.fwd ? (st.cnt == `VTE_FWD_CYCLES) : (st.cnt == `VTE_REV_CYCLES);
    end
    // quadrant unfold of the generated cosine and sine
    ang = st.fwd ? st.fwd_ang : st.rev_ang;
    unique case (ang[11:10])
      2'd0: begin c = 32'(st.cx); s = 32'(st.cy); end
      2'd1: begin c = -32'(st.cy); s = 32'(st.cx); end
      2'd2: begin c = -32'(st.cx); s = -32'(st.cy); end
      2'd3: begin c = 32'(st.cy); s = -32'(st.cx); end
    endcase
    // results land only at completion
    if (done) begin
      next_st.busy = 1'b0;
      if (st.fwd) begin
        vx = 32'(vte_sat(vte_mul(32'(st.vd), c) - vte_mul(32'(st.vq), s)));
        vy = 32'(vte_sat(vte_mul(32'(st.vd), s) + vte_mul(32'(st.vq), c)));
        next_st.pv_a = vte_sat(vx);
        next_st.pv_b = vte_sat(-(vx >>> 1) - vte_mul(vy, `VTE_SQRT3_HALF));
        next_st.pv_c = vte_sat(-(vx >>> 1) + vte_mul(vy, `VTE_SQRT3_HALF));
      end else begin
        b = 32'(st.ph_b);
        cc = 32'(st.ph_c);
        if (st.ctrl[`VTE_CTRL_THREE_IN]) begin
          al = st.ph_a;
        end else begin
          al = vte_sat(-(b + cc));
        end
        be = vte_sat(vte_mul(cc - b, `VTE_INV_SQRT3));
        a = 32'(al);
        next_st.ialpha = al;
        next_st.ibeta = be;
        next_st.flux = vte_sat(vte_mul(a, c) + vte_mul(32'(be), s));
        next_st.torque = vte_sat(vte_mul(32'(be), c) - vte_mul(a, s));
      end
    end
    // status flags: read clears, a completion in the same cycle wins
    if (rd_edge && st.s_addr1 == `VTE_ADDR_STAT) begin
      next_st.flag_xform = 1'b0;
      next_st.flag_sum = 1'b0;
    end
    if (done) begin
      next_st.flag_xform = 1'b1;
    end
    if (done && st.ctrl[`VTE_CTRL_IRQ_EN]) begin
      next_st.flag_sum = 1'b1;
    end
    next_st.irq_pulse = done && st.ctrl[`VTE_CTRL_IRQ_EN];
    // read data path
    next_st.drive = !st.s_cs_n[1] && !st.s_rd_n[1];
    unique case (st.s_addr1)
      `VTE_ADDR_PH_A: next_st.rdata = st.ph_a;
      `VTE_ADDR_PH_B: next_st.rdata = st.ph_b;
      `VTE_ADDR_PH_C: next_st.rdata = st.ph_c;
      `VTE_ADDR_REV_ANG: next_st.rdata = st.rev_ang;
      `VTE_ADDR_FWD_ANG: next_st.rdata = st.fwd_ang;
      `VTE_ADDR_VD: next_st.rdata = st.vd;
      `VTE_ADDR_VQ: next_st.rdata = st.vq;
      `VTE_ADDR_FLUX: next_st.rdata = st.flux;
      `VTE_ADDR_TORQUE: next_st.rdata = st.torque;
      `VTE_ADDR_IALPHA: next_st.rdata = st.ialpha;
      `VTE_ADDR_IBETA: next_st.rdata = st.ibeta;
      `VTE_ADDR_PV_A: next_st.rdata = st.pv_a;
      `VTE_ADDR_PV_B: next_st.rdata = st.pv_b;
      `VTE_ADDR_PV_C: next_st.rdata = st.pv_c;
      `VTE_ADDR_CTRL: next_st.rdata = st.ctrl;
      `VTE_ADDR_STAT: begin
        // status value is latched before the clear takes effect
        next_st.rdata = 12'h000;
        next_st.rdata[`VTE_STAT_XFORM] = st.flag_xform;
        next_st.rdata[`VTE_STAT_BUSY] = st.busy;
        next_st.rdata[`VTE_STAT_SUMMARY] = st.flag_sum;
      end
    endcase
    if (!next_st.drive || st.drive) begin
      next_st.rdata = next_st.drive ? st.rdata : next_st.rdata;
    end
  end

  // ==================== state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.s_cs_n <= 2'h3;
      st.s_rd_n <= 2'h3;
      st.s_wr_n <= 2'h3;
      st.wr_d <= 1'b1;
      st.rd_d <= 1'b1;
      st.ctrl <= `VTE_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==================== pins
  assign port.ddata = st.rdata;
  assign port.ddata_oe_n = !st.drive;
  assign port.irq_o = 1'b0;
  assign port.irq_oe_n = st.ctrl[`VTE_CTRL_IRQ_LEVEL] ? !st.flag_sum : !st.irq_pulse;
endmodule // vte_engine
`default_nettype wire

/* File: include/vte_defines.svh */
// vte_defines.svh: offsets, field positions, reset values and cycle counts
// of the vector transform engine; included by both ends.
`ifndef VTE_DEFINES_SVH
`define VTE_DEFINES_SVH
// ==================== register offsets
`define VTE_ADDR_PH_A 4'h0
`define VTE_ADDR_PH_B 4'h1
`define VTE_ADDR_PH_C 4'h2
`define VTE_ADDR_REV_ANG 4'h3
`define VTE_ADDR_FWD_ANG 4'h4
`define VTE_ADDR_VD 4'h5
`define VTE_ADDR_VQ 4'h6
`define VTE_ADDR_FLUX 4'h7
`define VTE_ADDR_TORQUE 4'h8
`define VTE_ADDR_IALPHA 4'h9
`define VTE_ADDR_IBETA 4'hA
`define VTE_ADDR_PV_A 4'hB
`define VTE_ADDR_PV_B 4'hC
`define VTE_ADDR_PV_C 4'hD
`define VTE_ADDR_CTRL 4'hE
`define VTE_ADDR_STAT 4'hF
// ==================== field positions and reset values
`define VTE_CTRL_IRQ_EN 6
`define VTE_CTRL_IRQ_LEVEL 8
`define VTE_CTRL_THREE_IN 10
`define VTE_STAT_XFORM 1
`define VTE_STAT_BUSY 4
`define VTE_STAT_SUMMARY 11
`define VTE_CTRL_RESET 12'h000
// ==================== timing counts in system clock cycles
`define VTE_REV_CYCLES 6'd37
`define VTE_FWD_CYCLES 6'd40
`define VTE_CORDIC_STEPS 4'hE
`define VTE_HOST_PHASE 4'h6
`define VTE_HOST_GUARD 6'h2C
// ==================== fixed-point constants, Q2.14
`define VTE_KINV 18'sh026DD
`define VTE_INV_SQRT3 32'sh000024F3
`define VTE_SQRT3_HALF 32'sh0000376D
`endif

/* File: include/vte_pkg.sv */
// vte_pkg: shared types of the vector transform engine.
// assumes vte_defines.svh is on the include path.
package vte_pkg;
  typedef enum logic [1:0] {VTE_H_IDLE, VTE_H_SETUP, VTE_H_STROBE, VTE_H_HOLD} vte_hstate_t;
  typedef logic signed [11:0] vte_word_t;
endpackage

/* File: include/vte_port_if.sv */
// vte_port_if: parallel register port and interrupt line between the host
// and the engine; resolves the shared data bus and the open-drain irq line.
`timescale 1ns/10ps
`default_nettype none
interface vte_port_if;
  // strobes and address from the host
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [3:0] addr;
  // data bus halves and enables (enable low means driving)
  logic [11:0] hdata;
  logic hdata_oe_n;
  logic [11:0] ddata;
  logic ddata_oe_n;
  logic [11:0] data_bus;
  // open-drain interrupt line with pull-up
  logic irq_o;
  logic irq_oe_n;
  logic irq_n;
  // wire resolution: an undriven bus floats high
  assign data_bus = !hdata_oe_n ? hdata : (!ddata_oe_n ? ddata : 12'hFFF);
  assign irq_n = irq_oe_n ? 1'b1 : irq_o;
  modport dev (input cs_n, rd_n, wr_n, addr, data_bus,
               output ddata, ddata_oe_n, irq_o, irq_oe_n);
  modport host (output cs_n, rd_n, wr_n, addr, hdata, hdata_oe_n,
                input data_bus, irq_n);
endinterface
`default_nettype wire

/* File: logic/vte_host.sv */
// vte_host: register port master that drives the engine from a simple
// request port. assumes the engine runs on the same clock frequency.
`timescale 1ns/10ps
`default_nettype none
`include "vte_defines.svh"
module vte_host
  import vte_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [3:0] req_addr,
  input wire logic [11:0] req_wdata,
  output logic req_ready,
  output logic req_error,
  output logic rsp_valid,
  output logic [11:0] rsp_data,
  output logic irq_seen,
  // register port toward the engine
  vte_port_if.host port
);
  typedef struct packed {
    vte_hstate_t fsm;
    logic [3:0] tcnt;
    logic write;
    logic [3:0] addr;
    logic [11:0] wdata;
    logic [5:0] guard;
    logic three_in;
    logic err;
    logic rv;
    logic [11:0] rdata;
    logic [1:0] s_irq;
    logic [11:0] s_dat0;
    logic [11:0] s_dat1;
  } vte_host_state_t;

  vte_host_state_t st;
  vte_host_state_t next_st;

  // ==================== request acceptance
  always_comb begin
    logic xform_reg;
    xform_reg = req_addr != `VTE_ADDR_CTRL && req_addr != `VTE_ADDR_STAT;
    req_ready = st.fsm == VTE_H_IDLE && !(req_write && xform_reg && st.guard != 6'h00);
  end

  // ==================== next-state logic
  always_comb begin
    logic take;
    logic bad_fwd;
    take = req_valid && req_ready;
    bad_fwd = req_write && req_addr == `VTE_ADDR_FWD_ANG && !st.three_in;
    next_st = st;
    next_st.s_irq = {st.s_irq[0], port.irq_n};
    next_st.s_dat0 = port.data_bus;
    next_st.s_dat1 = st.s_dat0;
    next_st.err = 1'b0;
    next_st.rv = 1'b0;
    if (st.guard != 6'h00) begin
      next_st.guard = st.guard - 6'h01;
    end
    unique case (st.fsm)
      VTE_H_IDLE: begin
        if (take && bad_fwd) begin
          next_st.err = 1'b1;
        end else if (take) begin
          next_st.fsm = VTE_H_SETUP;
          next_st.tcnt = `VTE_HOST_PHASE;
          next_st.write = req_write;
          next_st.addr = req_addr;
          next_st.wdata = req_wdata;
        end
      end
      VTE_H_SETUP: begin
        next_st.tcnt = st.tcnt - 4'h1;
        if (st.tcnt == 4'h1) begin
          next_st.fsm = VTE_H_STROBE;
          next_st.tcnt = `VTE_HOST_PHASE;
        end
      end
      VTE_H_STROBE: begin
        next_st.tcnt = st.tcnt - 4'h1;
        if (st.tcnt == 4'h1) begin
          next_st.fsm = VTE_H_HOLD;
          next_st.tcnt = `VTE_HOST_PHASE;
          next_st.rdata = st.s_dat1;
          next_st.rv = !st.write;
        end
      end
      VTE_H_HOLD: begin
        next_st.tcnt = st.tcnt - 4'h1;
        if (st.tcnt == 4'h1) begin
          next_st.fsm = VTE_H_IDLE;
          if (st.write && st.addr == `VTE_ADDR_CTRL) begin
            next_st.three_in = st.wdata[`VTE_CTRL_THREE_IN];
          end
          if (st.write && (st.addr == `VTE_ADDR_REV_ANG || st.addr == `VTE_ADDR_FWD_ANG)) begin
            next_st.guard = `VTE_HOST_GUARD;
          end
        end
      end
    endcase
  end

  // ==================== state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.fsm <= VTE_H_IDLE;
      st.s_irq <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  // ==================== outputs
  assign port.cs_n = st.fsm == VTE_H_IDLE;
  assign port.wr_n = !(st.fsm == VTE_H_STROBE && st.write);
  assign port.rd_n = !(st.fsm == VTE_H_STROBE && !st.write);
  assign port.addr = st.addr;
  assign port.hdata = st.wdata;
  assign port.hdata_oe_n = !(st.fsm != VTE_H_IDLE && st.write);
  assign req_error = st.err;
  assign rsp_valid = st.rv;
  assign rsp_data = st.rdata;
  assign irq_seen = !st.s_irq[1];
endmodule // vte_host
`default_nettype wire

/* File: verif/vte_checker_sva.sv */
// vte_checker_sva.sv: assertions on the port wires between host and engine.
// assumes the wires of vte_port_if and a single clock domain.
`timescale 1ns/10ps
`default_nettype none
module vte_checker_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // port wires
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [11:0] data_bus,
  input wire logic hdata_oe_n,
  input wire logic ddata_oe_n,
  input wire logic irq_n
);
  logic last_wr;
  logic fwd;
  logic [11:0] ctl;
  logic [7:0] cnt;
  wire logic wr_up = wr_n & ~last_wr & ~cs_n;
  // ====================
  // helper state
  // control shadow and cycles since the last angle write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_wr <= 1'h1;
      ctl <= 12'h000;
      cnt <= 8'hFF;
      fwd <= 1'h0;
    end else begin
      last_wr <= wr_n;
      if (wr_up && addr == 4'hE) ctl <= data_bus;
      if (wr_up && (addr == 4'h3 || addr == 4'h4)) begin
        cnt <= 8'h00;
        fwd <= addr[2];
      end else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
    end
  end
  // ====================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_done_time;
    $fell(irq_n) |-> (fwd ? (cnt >= 8'h29 && cnt <= 8'h2F) : (cnt >= 8'h26 && cnt <= 8'h2C));
  endproperty
  a_done_time: assert property (p_done_time) else $error("completion off time");
  property p_irq_enable;
    $fell(irq_n) |-> ctl[6];
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("irq while disabled");
  property p_pulse_one;
    $fell(irq_n) && !ctl[8] |=> irq_n;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("irq pulse too long");
  property p_level_hold;
    $fell(irq_n) && ctl[8] |=> !irq_n [*8];
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level irq dropped");
  property p_level_clear;
    $rose(rd_n) && !cs_n && addr == 4'hF && !irq_n |-> ##[1:6] irq_n;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("irq kept after read");
  property p_dev_sel;
    !ddata_oe_n |-> !cs_n && hdata_oe_n;
  endproperty
  a_dev_sel: assert property (p_dev_sel) else $error("engine drives unselected");
  property p_wr_hold;
    $rose(wr_n) && !cs_n |-> (!cs_n && !hdata_oe_n) [*5];
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data not held");
  property p_wr_setup;
    $fell(wr_n) |-> !cs_n && !hdata_oe_n && $stable(addr);
  endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("write strobe unqualified");
  // main scenarios reached
  c_fwd: cover property ($fell(irq_n) && fwd);
  c_rev_level: cover property ($fell(irq_n) && !fwd && ctl[8]);
  c_stat_read: cover property ($rose(rd_n) && !cs_n && addr == 4'hF);
endmodule // vte_checker_sva
`default_nettype wire

/* File: verif/tb.sv */
// tb.sv: self-checking bench joining the host and the engine on one port.
// assumes both ends and the checker compiled; one 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk;
  logic rst_n;
  logic req_valid;
  logic req_write;
  logic [3:0] req_addr;
  logic [11:0] req_wdata;
  logic req_ready;
  logic req_error;
  logic rsp_valid;
  logic [11:0] rsp_data;
  logic irq_seen;
  int n_mismatch;
  int num_checks;
  real prev_flux;
  vte_port_if bus_if ();
  // ====================
  // ends under test and checker
  vte_engine u_vte_engine (.clk(clk), .rst_n(rst_n), .port(bus_if));
  vte_host u_vte_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .req_error(req_error), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .irq_seen(irq_seen), .port(bus_if));
  vte_checker_sva u_vte_checker_sva (.clk(clk), .rst_n(rst_n), .cs_n(bus_if.cs_n),
    .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .addr(bus_if.addr), .data_bus(bus_if.data_bus),
    .hdata_oe_n(bus_if.hdata_oe_n), .ddata_oe_n(bus_if.ddata_oe_n), .irq_n(bus_if.irq_n));
  // ====================
  // reporting and comparison
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bad(input string m);
    n_mismatch++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic cmp_eq(input logic [11:0] g, input logic [11:0] e, input string m);
    num_checks++;
    if (g !== e) bad(m);
  endtask
  task automatic cmp_near(input logic [11:0] g, input real e, input string m);
    int d;
    num_checks++;
    d = int'($signed(g)) - int'(e);
    if ($isunknown(g) || d > 3 || d < -3) bad(m);
  endtask
  function automatic real cs(input int a);
    return $cos(a * 3.14159265358979 / 2048.0);
  endfunction
  function automatic real sn(input int a);
    return $sin(a * 3.14159265358979 / 2048.0);
  endfunction
  function automatic real rv(input logic [11:0] v);
    return real'($signed(v));
  endfunction
  // ====================
  // request port drivers
  task automatic req(input logic w, input logic [3:0] a, input logic [11:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'h1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do begin @(posedge clk); n++; end while (req_ready !== 1'h1 && n < 500);
    req_valid <= 1'h0;
    if (n >= 500) bad("request not taken");
  endtask
  task automatic rd(input logic [3:0] a, output logic [11:0] v);
    int n;
    req(1'h0, a, 12'h000);
    n = 0;
    do begin @(posedge clk); n++; end while (rsp_valid !== 1'h1 && n < 100);
    if (n >= 100) bad("read answer missing");
    v = rsp_data;
  endtask
  // watches 80 cycles for the interrupt, then the line level left over
  task automatic wait_irq(input logic e, input logic lvl);
    logic s;
    s = 1'h0;
    repeat (80) begin @(posedge clk); if (irq_seen === 1'h1) s = 1'h1; end
    cmp_eq({11'h000, s}, {11'h000, e}, "irq seen");
    cmp_eq({11'h000, irq_seen}, {11'h000, lvl}, "irq level");
  endtask
  // ====================
  // scenarios
  // full reverse transform with all result and flag checks
  task automatic rev_run(input logic [11:0] ctl, a, b, c, input int ang);
    real x;
    real y;
    logic [11:0] v;
    x = ctl[10] ? rv(a) : -rv(b) - rv(c);
    y = (rv(c) - rv(b)) / $sqrt(3.0);
    req(1'h1, 4'hE, ctl);
    req(1'h1, 4'h1, b);
    req(1'h1, 4'h2, c);
    req(1'h1, 4'h0, a);
    req(1'h1, 4'h3, ang[11:0]);
    rd(4'h7, v);
    cmp_near(v, prev_flux, "flux before done");
    wait_irq(ctl[6], ctl[6] & ctl[8]);
    rd(4'hF, v);
    cmp_eq(v, ctl[6] ? 12'h802 : 12'h002, "status");
    rd(4'hF, v);
    cmp_eq(v, 12'h000, "status cleared");
    cmp_eq({11'h000, irq_seen}, 12'h000, "irq after read");
    rd(4'h9, v);
    cmp_near(v, x, "alpha");
    rd(4'hA, v);
    cmp_near(v, y, "beta");
    prev_flux = x * cs(ang) + y * sn(ang);
    rd(4'h7, v);
    cmp_near(v, prev_flux, "flux");
    rd(4'h8, v);
    cmp_near(v, y * cs(ang) - x * sn(ang), "torque");
  endtask
  task automatic t_reset;
    logic [11:0] v;
    rd(4'hE, v);
    cmp_eq(v, 12'h000, "control reset");
    rd(4'hF, v);
    cmp_eq(v, 12'h000, "status reset");
  endtask
  // two-input, pulse irq, phase a written but ignored
  task automatic t_rev_two;
    rev_run(12'h040, 12'h123, 12'h064, 12'hED4, 512);
  endtask
  // three-input, level irq, quarter turn
  task automatic t_rev_three;
    rev_run(12'h540, 12'h190, 12'hF38, 12'h000, 1024);
  endtask
  // interrupt disabled, zero angle
  task automatic t_no_irq;
    rev_run(12'h000, 12'h7FF, 12'h100, 12'hF00, 0);
  endtask
  // forward transform at three quarter turn
  task automatic t_fwd;
    real x;
    real y;
    logic [11:0] v;
    x = 300.0 * cs(3072) + 100.0 * sn(3072);
    y = 300.0 * sn(3072) - 100.0 * cs(3072);
    req(1'h1, 4'hE, 12'h440);
    req(1'h1, 4'h5, 12'h12C);
    req(1'h1, 4'h6, 12'hF9C);
    req(1'h1, 4'h4, 12'hC00);
    wait_irq(1'h1, 1'h0);
    rd(4'hF, v);
    cmp_eq(v, 12'h802, "fwd status");
    rd(4'hB, v);
    cmp_near(v, x, "phase a volt");
    rd(4'hC, v);
    cmp_near(v, -x / 2.0 - $sqrt(3.0) / 2.0 * y, "phase b volt");
    rd(4'hD, v);
    cmp_near(v, -x / 2.0 + $sqrt(3.0) / 2.0 * y, "phase c volt");
    rd(4'h7, v);
    cmp_near(v, prev_flux, "flux kept");
  endtask
  // forward request in two-input mode is refused by the host
  task automatic t_fwd_refused;
    logic e;
    logic [11:0] v;
    e = 1'h0;
    req(1'h1, 4'hE, 12'h040);
    req(1'h1, 4'h4, 12'h200);
    repeat (3) begin @(posedge clk); if (req_error === 1'h1) e = 1'h1; end
    cmp_eq({11'h000, e}, 12'h001, "refused forward");
    wait_irq(1'h0, 1'h0);
    rd(4'hF, v);
    cmp_eq(v, 12'h000, "no transform");
  endtask
  // ====================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    bad("timeout");
    finish_test;
  end
  initial begin
    rst_n = 1'h0;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = 4'h0;
    req_wdata = 12'h000;
    prev_flux = 0.0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    t_reset;
    t_rev_two;
    t_rev_three;
    t_fwd;
    t_no_irq;
    t_fwd_refused;
    finish_test;
  end
endmodule // tb
`default_nettype wire
